//--- rtl/rcs_defines.svh
/*
  Constants of the reset configuration sequencer: register offsets, field
  positions, reset values and search constants.
  Assumes it is included by the package and by the sequencer module.
*/
// How it works
// - Start on reset release when test high
// - Held reset: outputs, GPIOs, serial ports off
// - Held reset: load factory block, strap map
// - Held reset: calibrate and lock system PLL
// - Latch strap pins on reset release
// - Build default image, pins untouched
// - Strap picks serial protocol, SPI four-wire
// - Apply EEPROM device update, then restart
// - Probe EEPROM addresses at three speeds
// - Check selected internal config, skip if bad
// - Report load errors and loaded number
// - Config writes only its listed registers
// - Module settings take effect on trigger
// - Divider write recalibrates PLL; serial reconfigured
// - Load EEPROM block only if checksum passes
// - EEPROM config blocks at two offsets only
// - Search until range ends or block applied
// - Run internal hotfix before completion
// - Completion steps in fixed order
// - Complete with defaults; status records failures
// - Lowest power state that still boots
// - Released functions drop their power state
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

`define RCS_IMG_AW 8
`define RCS_REG_CTRL 8'h00
`define RCS_REG_STATUS 8'h04
`define RCS_REG_CFGINFO 8'h08

`define RCS_EE_BASE_ADDR 7'h50
`define RCS_EE_LAST_IDX 3'h7
`define RCS_EE_UPD_OFF 16'h0000
`define RCS_EE_CFG_OFF0 16'h0000
`define RCS_EE_CFG_OFF1 16'hF000
`define RCS_SPD_1M 2'h0
`define RCS_SPD_400K 2'h1
`define RCS_SPD_100K 2'h2

`define RCS_APLL_FBDIV_ADDR 8'h10
`define RCS_SERIAL_MODE_ADDR 8'h20
`define RCS_SERIAL_MODE_DEF 8'h02
`define RCS_SERIAL_PROTO_BIT 0
`define RCS_DEF_VALUE 8'h00
`define RCS_TRIG_NIBBLE 4'hF

`define RCS_MAP_RESET 16'h0540
`define RCS_MAP_CFG_LSB 0
`define RCS_MAP_EE_EN 4
`define RCS_MAP_PROTO 8

`define RCS_ST_ERR_OTP_CFG 8
`define RCS_ST_ERR_OTP_LOAD 9
`define RCS_ST_ERR_NO_EE 10
`define RCS_ST_ERR_EE_LOAD 11
`define RCS_ST_UPDATE 12
`define RCS_ST_HOTFIX 13
`define RCS_ST_DONE 16

`endif

//--- rtl/rcs_image_ram.sv
/*
  Internal register image: one write port, one read port, registered read.
  Assumes a single clock and a clock enable shared with the sequencer.
*/
module rcs_image_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

//--- rtl/rcs_pkg.sv
/*
  Types of the reset configuration sequencer: states, jobs, write records.
  Assumes rcs_defines.svh is on the include path.
*/
package rcs_pkg;
`include "rcs_defines.svh"

  typedef enum logic [4:0] {
    S_FACTORY, S_PLL0, S_HELD, S_DEFAULTS, S_PROBE, S_UPD_CHECK, S_UPD_LOAD,
    S_OTP_CHECK, S_OTP_LOAD, S_EE_CHECK, S_EE_LOAD, S_HOTFIX_CHECK, S_HOTFIX_RUN,
    S_RELOCK, S_SERIAL, S_APPLY, S_MON, S_ALARM, S_RUN
  } rcs_state_e;

  typedef enum logic [3:0] {
    OP_NONE, OP_FACTORY, OP_EE_PROBE, OP_UPD_CHECK, OP_UPD_LOAD, OP_OTP_CHECK,
    OP_OTP_LOAD, OP_EE_CHECK, OP_EE_LOAD, OP_HOTFIX_CHECK, OP_HOTFIX_RUN
  } rcs_op_e;

  typedef logic [`RCS_IMG_AW-1:0] rcs_addr_t;

  typedef struct packed {
    rcs_op_e op;
    logic [6:0] dev;
    logic [1:0] speed;
    logic [15:0] offset;
    logic [3:0] cfg;
  } rcs_job_s;

  typedef struct packed {
    logic valid;
    rcs_addr_t addr;
    logic [7:0] data;
  } rcs_wr_s;

  typedef struct packed {
    logic valid;
    logic trig;
    rcs_addr_t addr;
    logic [7:0] data;
  } rcs_live_s;
endpackage

//--- rtl/rcs_sequencer.sv
/*
  Reset configuration sequencer: from master reset through strap latch,
  default image, EEPROM update, internal and EEPROM configuration, hotfix
  and ordered completion, plus power and clock gating policy.
  Assumes inputs synchronous to MCLK, and job and PLL engines outside that
  answer each request with a one-cycle done pulse.
*/
// Design decisions made here: the placing of the registers and the plain strobed port.
`include "rcs_defines.svh"
module rcs_sequencer #(
  parameter int GW = 16
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic MASTER_RESET_N,
  input wire logic TEST_MODE_N,
  input wire logic [GW-1:0] STRAP_GPIO,
  output logic JOB_REQ,
  output rcs_pkg::rcs_job_s JOB,
  input wire logic JOB_DONE,
  input wire logic JOB_OK,
  input wire logic [15:0] JOB_DATA,
  input wire rcs_pkg::rcs_wr_s CFG_WR,
  output logic PLL_CAL,
  input wire logic PLL_DONE,
  output rcs_pkg::rcs_live_s LIVE_WR,
  output logic CLOCK_OUTPUTS_OE,
  output logic GPIO_OE,
  output logic SERIAL_EN,
  output logic SERIAL_PROTO,
  output logic MON_EN,
  output logic ALARM_EN,
  output logic BOOT_DONE,
  output logic [3:0] POWER_EN,
  output logic [3:0] CLOCK_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);
  import rcs_pkg::*;

  localparam rcs_addr_t AMAX = '1;

  function automatic logic [3:0] pick4(input logic [GW-1:0] g, input logic [3:0] base);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i] = g[(int'(base) + i) % GW];
    end
    return r;
  endfunction

  function automatic logic is_trigger(input rcs_addr_t a);
    return a[3:0] == `RCS_TRIG_NIBBLE;
  endfunction

  function automatic logic [7:0] default_of(input rcs_addr_t a, input logic proto);
    logic [7:0] v;
    v = `RCS_DEF_VALUE;
    if (a == `RCS_SERIAL_MODE_ADDR) begin
      v = `RCS_SERIAL_MODE_DEF;
      v[`RCS_SERIAL_PROTO_BIT] = proto;
    end
    return v;
  endfunction

  function automatic rcs_op_e op_of(input rcs_state_e s);
    case (s)
      S_FACTORY: return OP_FACTORY;
      S_PROBE: return OP_EE_PROBE;
      S_UPD_CHECK: return OP_UPD_CHECK;
      S_UPD_LOAD: return OP_UPD_LOAD;
      S_OTP_CHECK: return OP_OTP_CHECK;
      S_OTP_LOAD: return OP_OTP_LOAD;
      S_EE_CHECK: return OP_EE_CHECK;
      S_EE_LOAD: return OP_EE_LOAD;
      S_HOTFIX_CHECK: return OP_HOTFIX_CHECK;
      S_HOTFIX_RUN: return OP_HOTFIX_RUN;
      default: return OP_NONE;
    endcase
  endfunction

  rcs_state_e state, next_state;
  logic waiting, issue, pll_go, advance, pll_busy;
  logic mr_q, rise_pending, update_done, cfg_loaded, fbdiv_hit;
  logic [GW-1:0] strap;
  logic [15:0] strap_map;
  logic [3:0] cfg_num, srch, loaded_cfg, release_req;
  logic ee_en, proto_strap, done, last, otp_loaded, ee_loaded;
  logic [1:0] speed;
  logic [7:0] found;
  logic [2:0] ptr;
  logic [5:0] errs;
  logic [15:0] trig_mask;
  rcs_addr_t def_addr, apl_addr, apl_addr_q;
  logic apl_all, apl_valid, img_we, img_re, cfg_wr_ok;
  rcs_addr_t img_waddr;
  logic [7:0] img_wdata, img_rdata;

  assign done = JOB_DONE && waiting;
  assign cfg_num = pick4(strap, strap_map[`RCS_MAP_CFG_LSB +: 4]);
  assign ee_en = strap[strap_map[`RCS_MAP_EE_EN +: 4]];
  assign proto_strap = strap[strap_map[`RCS_MAP_PROTO +: 4]];
  assign ptr = (state inside {S_EE_CHECK, S_EE_LOAD}) ? srch[3:1] : srch[2:0];
  assign last = (state == S_EE_CHECK) ? (srch == 4'hF) : (srch[2:0] == `RCS_EE_LAST_IDX);
  assign cfg_wr_ok = CFG_WR.valid && waiting && (state == S_OTP_LOAD || state == S_EE_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Sequence control

  always_comb begin
    next_state = state;
    issue = 1'b0;
    pll_go = 1'b0;
    advance = 1'b0;
    case (state)
      S_FACTORY: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = S_PLL0;
      end
      S_PLL0: begin
        if (!waiting) pll_go = !pll_busy;
        else if (!pll_busy) next_state = S_HELD;
      end
      S_HELD: begin
        if (rise_pending || update_done) next_state = S_DEFAULTS;
      end
      S_DEFAULTS: begin
        if (def_addr == AMAX) next_state = S_PROBE;
      end
      S_PROBE: begin
        if (!ee_en) next_state = S_OTP_CHECK;
        else if (!waiting) issue = 1'b1;
        else if (done) begin
          // A speed step is taken only when no address answered at all
          if (srch[2:0] != `RCS_EE_LAST_IDX) advance = 1'b1;
          else if (found != 8'h00 || JOB_OK || speed == `RCS_SPD_100K) next_state = S_UPD_CHECK;
          else advance = 1'b1;
        end
      end
      S_UPD_CHECK, S_EE_CHECK: begin
        if (!ee_en || (state == S_UPD_CHECK && update_done)) begin
          next_state = (state == S_UPD_CHECK) ? S_OTP_CHECK : S_HOTFIX_CHECK;
        end else if (!waiting) begin
          if (found[ptr]) issue = 1'b1;
          else if (last) next_state = (state == S_UPD_CHECK) ? S_OTP_CHECK : S_HOTFIX_CHECK;
          else advance = 1'b1;
        end else if (done) begin
          if (JOB_OK) next_state = (state == S_UPD_CHECK) ? S_UPD_LOAD : S_EE_LOAD;
          else if (last) next_state = (state == S_UPD_CHECK) ? S_OTP_CHECK : S_HOTFIX_CHECK;
          else advance = 1'b1;
        end
      end
      S_UPD_LOAD: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = S_FACTORY;
      end
      S_OTP_CHECK: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = JOB_OK ? S_OTP_LOAD : S_EE_CHECK;
      end
      S_OTP_LOAD: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = S_EE_CHECK;
      end
      S_EE_LOAD: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = S_HOTFIX_CHECK;
      end
      S_HOTFIX_CHECK: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = JOB_OK ? S_HOTFIX_RUN : S_RELOCK;
      end
      S_HOTFIX_RUN: begin
        if (!waiting) issue = 1'b1;
        else if (done) next_state = S_RELOCK;
      end
      S_RELOCK: begin
        // A parallel recalibration still running is waited out first
        if (!cfg_loaded) next_state = S_SERIAL;
        else if (!waiting) pll_go = !pll_busy;
        else if (!pll_busy) next_state = S_SERIAL;
      end
      S_SERIAL: next_state = S_APPLY;
      S_APPLY: begin
        if (apl_valid && apl_addr_q == AMAX) next_state = S_MON;
      end
      S_MON: next_state = S_ALARM;
      S_ALARM: next_state = S_RUN;
      S_RUN: next_state = S_RUN;
      default: next_state = S_FACTORY;
    endcase
    if ((state == S_OTP_LOAD || state == S_EE_LOAD) && done && JOB_OK && fbdiv_hit && !pll_busy) begin
      pll_go = 1'b1;
    end
    if (!MASTER_RESET_N && !(state inside {S_FACTORY, S_PLL0, S_HELD})) begin
      next_state = S_FACTORY;
      issue = 1'b0;
      pll_go = 1'b0;
      advance = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state <= S_FACTORY;
      waiting <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      waiting <= (next_state == state) && ((waiting && !done) || issue || pll_go);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      srch <= 4'h0;
      speed <= `RCS_SPD_1M;
      found <= 8'h00;
    end else if (CE) begin
      // A load keeps the search position so it reads the block just checked
      if (next_state != state && !(next_state inside {S_UPD_LOAD, S_EE_LOAD})) srch <= 4'h0;
      else if (advance) srch <= srch + 4'h1;
      if (state == S_DEFAULTS) begin
        speed <= `RCS_SPD_1M;
        found <= 8'h00;
      end else if (state == S_PROBE && done) begin
        if (JOB_OK) found[srch[2:0]] <= 1'b1;
        if (advance && srch[2:0] == `RCS_EE_LAST_IDX) speed <= speed + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master reset edge, straps, restart

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mr_q <= 1'b0;
      rise_pending <= 1'b0;
      strap <= '0;
      update_done <= 1'b0;
    end else if (CE) begin
      mr_q <= MASTER_RESET_N;
      if (MASTER_RESET_N && !mr_q) strap <= STRAP_GPIO;
      if (MASTER_RESET_N && !mr_q && TEST_MODE_N) rise_pending <= 1'b1;
      else if (!MASTER_RESET_N || (state == S_HELD && next_state != S_HELD)) rise_pending <= 1'b0;
      // One update per master reset, so a block still in EEPROM cannot loop
      if (!MASTER_RESET_N) update_done <= 1'b0;
      else if (state == S_UPD_LOAD && done) update_done <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      strap_map <= `RCS_MAP_RESET;
    end else if (CE && state == S_FACTORY && done) begin
      strap_map <= JOB_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Job and PLL requests

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      JOB_REQ <= 1'b0;
      JOB <= '0;
    end else if (CE) begin
      JOB_REQ <= issue;
      if (issue) begin
        JOB.op <= op_of(state);
        JOB.cfg <= cfg_num;
        JOB.speed <= speed;
        JOB.dev <= `RCS_EE_BASE_ADDR + {4'h0, (state == S_PROBE) ? srch[2:0] : ptr};
        if (state == S_EE_CHECK || state == S_EE_LOAD) begin
          JOB.offset <= srch[0] ? `RCS_EE_CFG_OFF1 : `RCS_EE_CFG_OFF0;
        end else begin
          JOB.offset <= `RCS_EE_UPD_OFF;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PLL_CAL <= 1'b0;
      pll_busy <= 1'b0;
    end else if (CE) begin
      PLL_CAL <= pll_go;
      if (pll_go) pll_busy <= 1'b1;
      else if (PLL_DONE) pll_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration snooping and load results

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      fbdiv_hit <= 1'b0;
      trig_mask <= 16'h0000;
      SERIAL_PROTO <= 1'b0;
    end else if (CE) begin
      if (issue) fbdiv_hit <= 1'b0;
      else if (cfg_wr_ok && CFG_WR.addr == `RCS_APLL_FBDIV_ADDR) fbdiv_hit <= 1'b1;
      if (state == S_DEFAULTS) trig_mask <= 16'h0000;
      else if (cfg_wr_ok && is_trigger(CFG_WR.addr)) trig_mask[CFG_WR.addr[7:4]] <= 1'b1;
      if (state == S_DEFAULTS) SERIAL_PROTO <= proto_strap;
      else if (cfg_wr_ok && CFG_WR.addr == `RCS_SERIAL_MODE_ADDR) begin
        SERIAL_PROTO <= CFG_WR.data[`RCS_SERIAL_PROTO_BIT];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cfg_loaded <= 1'b0;
      otp_loaded <= 1'b0;
      ee_loaded <= 1'b0;
      loaded_cfg <= 4'h0;
    end else if (CE) begin
      if (state == S_DEFAULTS) begin
        cfg_loaded <= 1'b0;
        otp_loaded <= 1'b0;
        ee_loaded <= 1'b0;
      end else if (done && JOB_OK && state == S_OTP_LOAD) begin
        cfg_loaded <= 1'b1;
        otp_loaded <= 1'b1;
        loaded_cfg <= cfg_num;
      end else if (done && JOB_OK && state == S_EE_LOAD) begin
        cfg_loaded <= 1'b1;
        ee_loaded <= 1'b1;
      end
    end
  end

  // Sticky failure, update and hotfix flags; a new event wins over a software clear
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      errs <= 6'h00;
    end else if (CE) begin
      for (int i = 0; i < 6; i++) begin
        if (REG_WR && REG_ADDR == `RCS_REG_STATUS && REG_WDATA[`RCS_ST_ERR_OTP_CFG + i]) errs[i] <= 1'b0;
      end
      if (done && !JOB_OK && state == S_OTP_CHECK) errs[0] <= 1'b1;
      if (done && !JOB_OK && state == S_OTP_LOAD) errs[1] <= 1'b1;
      if (state == S_PROBE && next_state == S_UPD_CHECK && found == 8'h00 && !JOB_OK) errs[2] <= 1'b1;
      if (done && !JOB_OK && state == S_EE_LOAD) errs[3] <= 1'b1;
      if (done && state == S_UPD_LOAD) errs[4] <= 1'b1;
      if (done && state == S_HOTFIX_RUN) errs[5] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register image: defaults, configuration writes, apply

  assign img_we = (state == S_DEFAULTS) || cfg_wr_ok;
  assign img_waddr = (state == S_DEFAULTS) ? def_addr : CFG_WR.addr;
  assign img_wdata = (state == S_DEFAULTS) ? default_of(def_addr, proto_strap) : CFG_WR.data;
  assign img_re = (state == S_APPLY) && !apl_all;

  rcs_image_ram #(.AW(`RCS_IMG_AW), .DW(8)) u_image (
    .clk(MCLK),
    .ce(CE),
    .we(img_we),
    .waddr(img_waddr),
    .wdata(img_wdata),
    .re(img_re),
    .raddr(apl_addr),
    .rdata(img_rdata)
  );

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      def_addr <= '0;
      apl_addr <= '0;
      apl_all <= 1'b0;
      apl_valid <= 1'b0;
      apl_addr_q <= '0;
    end else if (CE) begin
      def_addr <= (state == S_DEFAULTS) ? def_addr + rcs_addr_t'(1) : '0;
      if (state != S_APPLY) begin
        apl_addr <= '0;
        apl_all <= 1'b0;
      end else if (img_re) begin
        apl_addr <= apl_addr + rcs_addr_t'(1);
        apl_all <= (apl_addr == AMAX);
      end
      apl_valid <= img_re;
      apl_addr_q <= apl_addr;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      LIVE_WR <= '0;
    end else if (CE) begin
      LIVE_WR.valid <= apl_valid;
      LIVE_WR.addr <= apl_addr_q;
      LIVE_WR.data <= img_rdata;
      LIVE_WR.trig <= apl_valid && is_trigger(apl_addr_q) && trig_mask[apl_addr_q[7:4]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion enables and power policy

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SERIAL_EN <= 1'b0;
      CLOCK_OUTPUTS_OE <= 1'b0;
      GPIO_OE <= 1'b0;
      MON_EN <= 1'b0;
      ALARM_EN <= 1'b0;
      BOOT_DONE <= 1'b0;
    end else if (CE) begin
      SERIAL_EN <= next_state inside {S_APPLY, S_MON, S_ALARM, S_RUN};
      CLOCK_OUTPUTS_OE <= next_state inside {S_MON, S_ALARM, S_RUN};
      GPIO_OE <= next_state inside {S_MON, S_ALARM, S_RUN};
      MON_EN <= next_state inside {S_ALARM, S_RUN};
      ALARM_EN <= next_state == S_RUN;
      BOOT_DONE <= next_state == S_RUN;
    end
  end

  // Function 0 boot loader, 1 outputs, 2 monitors, 3 PLL state machines
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      POWER_EN <= 4'h1;
      CLOCK_EN <= 4'h1;
    end else if (CE) begin
      POWER_EN <= {next_state inside {S_MON, S_ALARM, S_RUN}, next_state inside {S_APPLY, S_MON, S_ALARM, S_RUN},
                   next_state inside {S_APPLY, S_MON, S_ALARM, S_RUN}, next_state != S_RUN} & ~release_req;
      CLOCK_EN <= {next_state inside {S_ALARM, S_RUN}, next_state inside {S_MON, S_ALARM, S_RUN},
                   next_state inside {S_MON, S_ALARM, S_RUN}, next_state != S_RUN} & ~release_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      release_req <= 4'h0;
    end else if (CE && REG_WR && REG_ADDR == `RCS_REG_CTRL) begin
      release_req <= REG_WDATA[3:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (CE) begin
      REG_RDATA <= 32'h0000_0000;
      if (REG_RD) begin
        case (REG_ADDR)
          `RCS_REG_CTRL: REG_RDATA <= {28'h0, release_req};
          `RCS_REG_STATUS: REG_RDATA <= {15'h0, BOOT_DONE, 2'h0, errs, 3'h0, state};
          `RCS_REG_CFGINFO: REG_RDATA <= {14'h0, speed, found, 2'h0, ee_loaded, otp_loaded, loaded_cfg};
          default: REG_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- test/rcs_board_model.sv
/*
  Job and PLL engines with the board behind them: OTP, EEPROMs, PLL.
  Assumes requests are sampled at rising MCLK edges.
*/
module rcs_board_model (
  input wire logic MCLK,
  input wire logic JOB_REQ,
  input wire rcs_pkg::rcs_job_s JOB,
  input wire logic PLL_CAL,
  input wire logic ee_present,
  input wire logic otp_good,
  input wire logic slow,
  output logic JOB_DONE,
  output logic JOB_OK,
  output logic [15:0] JOB_DATA,
  output rcs_pkg::rcs_wr_s CFG_WR,
  output logic PLL_DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  rcs_job_s job;
  int i;
  function automatic logic ok_of(rcs_job_s j);
    case (j.op)
      OP_EE_PROBE: return ee_present && j.dev == 7'h52;
      OP_UPD_CHECK: return ee_present && !otp_good;
      OP_OTP_CHECK: return otp_good;
      OP_EE_CHECK: return j.offset == 16'hF000;
      OP_EE_LOAD: return j.dev == 7'h52 && j.offset == 16'hF000;
      default: return 1'b1;
    endcase
  endfunction
  initial begin
    JOB_DONE = 1'b0;
    JOB_OK = 1'b0;
    JOB_DATA = 16'hFABF;
    CFG_WR = '0;
    forever begin
      @(posedge MCLK);
      if (JOB_REQ) begin
        job = JOB;
        repeat (slow ? 9 : 2) @(posedge MCLK);
        if (job.op == OP_OTP_LOAD || job.op == OP_EE_LOAD) begin
          // Divider, then an all-zero trigger byte that must still fire; every OTP or EEPROM config load writes both
          for (i = 0; i < 2; i++) begin
            CFG_WR <= '{1'b1, i ? 8'h2F : 8'h10, i ? 8'h00 : 8'h5A};
            @(posedge MCLK);
          end
        end
        CFG_WR <= '{1'b0, 8'hA5, 8'hA5};
        JOB_OK <= ok_of(job);
        JOB_DATA <= 16'h0540;
        JOB_DONE <= 1'b1;
        @(posedge MCLK);
        JOB_DONE <= 1'b0;
        JOB_OK <= ~JOB_OK;
        JOB_DATA <= 16'hFABF;
      end
    end
  end
  initial begin
    PLL_DONE = 1'b0;
    forever begin
      @(posedge MCLK);
      if (PLL_CAL) begin
        repeat (slow ? 20 : 3) @(posedge MCLK);
        PLL_DONE <= 1'b1;
        @(posedge MCLK);
        PLL_DONE <= 1'b0;
      end
    end
  end
endmodule

//--- test/rcs_sequencer_props.sv
/*
  Checker on the ports of rcs_sequencer, attached by bind.
  Assumes the single clock MCLK and the synchronous reset SRST.
*/
module rcs_sequencer_props (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic MASTER_RESET_N,
  input wire logic REG_RD,
  input wire logic JOB_REQ,
  input wire rcs_pkg::rcs_live_s LIVE_WR,
  input wire logic CLOCK_OUTPUTS_OE,
  input wire logic GPIO_OE,
  input wire logic SERIAL_EN,
  input wire logic MON_EN,
  input wire logic ALARM_EN,
  input wire logic BOOT_DONE,
  input wire logic [31:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////
  a_held_quiet: assert property (!MASTER_RESET_N |=> !CLOCK_OUTPUTS_OE && !GPIO_OE && !SERIAL_EN)
    else $error("pins driven while held");
  a_job_pulse: assert property (JOB_REQ |=> !JOB_REQ)
    else $error("job request too long");
  a_apply_start: assert property ($rose(SERIAL_EN) |-> ##2 LIVE_WR.valid && LIVE_WR.addr == 8'h00)
    else $error("apply not after serial enable");
  a_outputs_late: assert property ($rose(GPIO_OE) |-> CLOCK_OUTPUTS_OE && LIVE_WR.valid
    && LIVE_WR.addr == 8'hFF)
    else $error("outputs before image applied");
  a_mon_order: assert property ($rose(MON_EN) |-> $past(GPIO_OE) ##1 (ALARM_EN && BOOT_DONE))
    else $error("monitor and alarm order");
  a_done_full: assert property (BOOT_DONE |-> SERIAL_EN && MON_EN && ALARM_EN)
    else $error("done without enables");
  a_read_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
    else $error("read data without read");
  a_apply_walk: assert property (LIVE_WR.valid && LIVE_WR.addr != 8'hFF |=> LIVE_WR.valid
    && LIVE_WR.addr == $past(LIVE_WR.addr) + 8'h01)
    else $error("image byte skipped");
endmodule

bind rcs_sequencer rcs_sequencer_props u_props (.MCLK, .SRST, .MASTER_RESET_N, .REG_RD, .JOB_REQ, .LIVE_WR,
  .CLOCK_OUTPUTS_OE, .GPIO_OE, .SERIAL_EN, .MON_EN, .ALARM_EN, .BOOT_DONE, .REG_RDATA);

//--- test/rcs_sequencer_test.sv
/*
  Self-checking bench of rcs_sequencer with the board model.
  Assumes the design answers register reads one cycle later.
*/
module rcs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  logic MCLK = 1'b0, SRST = 1'b1, CE = 1'b1, MASTER_RESET_N = 1'b0, TEST_MODE_N = 1'b1;
  logic [15:0] STRAP_GPIO = 16'h0000;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
  logic REG_WR = 1'b0, REG_RD = 1'b0, ee_present = 1'b0, otp_good = 1'b0, slow = 1'b1;
  logic JOB_REQ, JOB_DONE, JOB_OK, PLL_CAL, PLL_DONE, CLOCK_OUTPUTS_OE, GPIO_OE, SERIAL_EN;
  logic SERIAL_PROTO, MON_EN, ALARM_EN, BOOT_DONE;
  logic [15:0] JOB_DATA;
  logic [3:0] POWER_EN, CLOCK_EN;
  rcs_job_s JOB;
  rcs_wr_s CFG_WR;
  rcs_live_s LIVE_WR;
  logic [7:0] img [256];
  logic trg [256];
  int n_mismatch = 0, checks = 0;
  rcs_sequencer dut (.MCLK, .SRST, .CE, .MASTER_RESET_N, .TEST_MODE_N, .STRAP_GPIO, .JOB_REQ, .JOB, .JOB_DONE,
    .JOB_OK, .JOB_DATA, .CFG_WR, .PLL_CAL, .PLL_DONE, .LIVE_WR, .CLOCK_OUTPUTS_OE, .GPIO_OE, .SERIAL_EN,
    .SERIAL_PROTO, .MON_EN, .ALARM_EN, .BOOT_DONE, .POWER_EN, .CLOCK_EN, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA);
  rcs_board_model board (.MCLK, .JOB_REQ, .JOB, .PLL_CAL, .ee_present, .otp_good, .slow, .JOB_DONE, .JOB_OK,
    .JOB_DATA, .CFG_WR, .PLL_DONE);
  always #5 MCLK = ~MCLK;
  always @(posedge MCLK) if (LIVE_WR.valid) begin
    img[LIVE_WR.addr] <= LIVE_WR.data;
    trg[LIVE_WR.addr] <= LIVE_WR.trig;
  end
  ////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_rd(logic [7:0] a);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic reg_wr(logic [7:0] a, logic [31:0] w);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= w;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task automatic boot(logic [15:0] strap, logic test_n, int wait_n);
    @(posedge MCLK);
    MASTER_RESET_N <= 1'b0;
    repeat (60) @(posedge MCLK);
    STRAP_GPIO <= strap;
    TEST_MODE_N <= test_n;
    @(posedge MCLK);
    MASTER_RESET_N <= 1'b1;
    repeat (2) @(posedge MCLK);
    STRAP_GPIO <= ~strap; // Board lets go of the straps after a short hold
    for (int i = 0; i < wait_n && BOOT_DONE !== 1'b1; i++) @(posedge MCLK);
  endtask
  task automatic t_held();
    repeat (3) @(posedge MCLK);
    check("held pins", {CLOCK_OUTPUTS_OE, GPIO_OE, SERIAL_EN}, 0);
    check("held power", POWER_EN, 4'h1);
    reg_wr(8'hFC, 32'hFFFFFFFF);
    reg_rd(8'hFC);
    check("unmapped", d, 0);
  endtask
  task automatic t_test_mode();
    boot(16'h0015, 1'b0, 400);
    check("test mode done", BOOT_DONE, 0);
    reg_rd(`RCS_REG_STATUS);
    check("test mode state", d[4:0], 5'd2);
  endtask
  task automatic t_no_config();
    boot(16'h0015, 1'b1, 4000);
    check("done", BOOT_DONE, 1);
    check("proto i2c", SERIAL_PROTO, 0);
    reg_rd(`RCS_REG_STATUS);
    check("fail bits", {d[16], d[10], d[8]}, 3'b111);
    reg_rd(`RCS_REG_CFGINFO);
    check("none loaded", d[5:4], 0);
    check("default div", img[8'h10], 0);
    check("serial default", img[8'h20], 8'h02);
    reg_wr(`RCS_REG_STATUS, 32'h3F00);
    reg_rd(`RCS_REG_STATUS);
    check("cleared", d[13:8], 0);
  endtask
  task automatic t_full();
    {ee_present, otp_good, slow} = 3'b110;
    boot(16'h0033, 1'b1, 4000);
    check("proto spi", SERIAL_PROTO, 1);
    reg_rd(`RCS_REG_CFGINFO);
    check("cfginfo", {d[17:8], d[5:0]}, {2'h0, 8'h04, 6'h33});
    reg_rd(`RCS_REG_STATUS);
    check("hotfix ok", {d[13], d[11], d[8]}, 3'b100);
    check("divider", img[8'h10], 8'h5A);
    check("untouched", img[8'h11], 0);
    check("spi 4-wire", img[8'h20], 8'h03);
    check("trigger", {trg[8'h2F], trg[8'h1F]}, 2'b10);
  endtask
  task automatic t_update();
    {ee_present, otp_good} = 2'b10;
    boot(16'h0033, 1'b1, 4000);
    reg_rd(`RCS_REG_STATUS);
    check("update restart", {d[16], d[12], d[11]}, 3'b110);
    reg_rd(`RCS_REG_CFGINFO);
    check("ee after update", d[5:4], 2'b10);
  endtask
  task automatic t_release();
    reg_wr(`RCS_REG_CTRL, 32'h2);
    repeat (3) @(posedge MCLK);
    check("released", {POWER_EN[2:1], CLOCK_EN[2:1]}, 4'hA);
    reg_rd(`RCS_REG_CTRL);
    check("ctrl", d, 32'h2);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    SRST <= 1'b0;
    t_held();
    t_test_mode();
    t_no_config();
    t_full();
    t_update();
    t_release();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
